// ### logic/outport_pkg.sv
// Purpose: constants and carriers for the output port and special output bank
// Assumes: avalon-mm byte addressing, one register per aligned 32-bit word
// Notes: printed offsets are word indices, so byte address is four times the index
package outport_pkg;
   // register indices as printed, byte address is index * 4
   localparam logic [23:0] lcd_ctl_idx = 24'h00ff10;
   localparam logic [23:0] tmr_mode_idx = 24'h00ff30;
   localparam logic [23:0] ctimer_idx = 24'h00ff40;
   localparam logic [23:0] buzz_idx = 24'h00ff44;
   localparam logic [23:0] port3_idx = 24'h00ff76;
   localparam logic [23:0] port4_idx = 24'h00ff77;
   localparam logic [23:0] port5_idx = 24'h00ff78;
   localparam logic [23:0] build_opt_idx = 24'h00ff7c;
   localparam int addr_w = 26;
   // reset values
   localparam logic [7:0] port3_rst = 8'hff;
   localparam logic [7:0] port4_rst = 8'hff;
   localparam logic [1:0] port5_rst = 2'h2;
   // bit positions
   localparam int lcd_clk_pos = 4;
   localparam int lcd_frm_pos = 3;
   localparam int font_pos = 2;
   localparam int duty_pos = 1;
   localparam int lcd_rsv_pos = 0;
   localparam int width_pos = 4;
   localparam int chan_pos = 3;
   localparam int tone_pos = 2;
   localparam int psc1_pos = 1;
   localparam int psc0_pos = 0;
   localparam int stop_pos = 6;
   localparam int shot_pos = 5;
   localparam int len_pos = 4;
   localparam int decay_pos = 3;
   localparam int erst_pos = 2;
   localparam int env_pos = 1;
   localparam int bz_pos = 0;
   localparam int fsel_lo = 4;
   localparam int fout_pos = 3;
   localparam int tmrun_pos = 0;
   // times, and cycle counts at 200 MHz
   localparam longint clk_hz = 200000000;
   localparam longint shot_short_us = 31250;
   localparam longint shot_long_us = 125000;
   localparam longint shot_short_cyc = shot_short_us * clk_hz / 1000000;
   localparam longint shot_long_cyc = shot_long_us * clk_hz / 1000000;
   localparam longint decay_short_ms = 500;
   localparam longint decay_long_ms = 1000;
   localparam longint decay_short_cyc = decay_short_ms * clk_hz / 1000;
   localparam longint decay_long_cyc = decay_long_ms * clk_hz / 1000;
   // avalon request carrier
   typedef struct packed {
      logic rd;
      logic wr;
      logic [addr_w-1:0] addr;
      logic [31:0] wdata;
   } av_req_t;
   // lcd control fields
   typedef struct packed {
      logic clk_en;
      logic frm_en;
      logic font;
      logic duty;
      logic rsv;
   } lcd_ctl_t;
   // timer mode fields
   typedef struct packed {
      logic width;
      logic chan;
      logic tone;
      logic psc1;
      logic psc0;
   } tmr_mode_t;
   // buzzer fields
   typedef struct packed {
      logic len;
      logic decay;
      logic env;
      logic bz;
   } buzz_t;
   // bus states
   typedef enum logic [1:0] {
      bus_idle = 2'b00,
      bus_ack = 2'b01
   } bus_state_t;
endpackage : outport_pkg

// ### logic/outport_bank.sv
// Purpose: output port data and special output control register bank
// Assumes: inputs synchronous to sys_clk; oscillator ticks are enable pulses
// Notes: one wait state on every access; unmapped reads return zero
//
// Summary of operation
// - third port data byte drives pins, read-write, resets to all ones
// - next register is eight reserved read-write bits resetting to ones
// - fifth port uses two low bits; bit0 resets 0, bit1 resets 1
// - lcd control d4 enables lcd clock output, resets 0
// - lcd control d3 enables lcd frame output, resets 0
// - lcd control d2 picks 5x5 font when 1, 5x8 when 0
// - lcd control d1 picks 1/16 duty when 1, 1/32 when 0
// - eighth duty build option makes the duty bit ineffective
// - timer mode d4 joins two 8-bit timers into one 16-bit
// - timer mode d3 picks timer 1 or timer 0 for tone pin
// - timer mode d2 turns tone output on or off
// - timer mode d1,d0 pick high or low oscillator for prescalers
// - writing 1 to buzzer d6 stops a one-shot at once; reads 0
// - writing 1 to d5 starts a one-shot; reads 1 while busy
// - buzzer d4 picks one-shot length 125 ms or 31.25 ms
// - buzzer d3 picks envelope decay 1 s or 0.5 s
// - writing 1 to d2 restarts the envelope; reads 0
// - d1 envelope enable; hardware clears it during a one-shot
// - buzzer d0 turns buzzer output on or off
// - clock timer d6..d4 pick low or high oscillator divided by 2, 4, 8 or 16
// - clock timer d3 drives the selected frequency onto its pin
// - a pin carrying a special output stops following its port bit
//
// Our own choice: the Avalon-MM interface to the registers.
module outport_bank (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // avalon-mm slave
   input wire logic [outport_pkg::addr_w-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // oscillator enable ticks and special sources
   input wire logic low_speed_osc,
   input wire logic high_speed_osc,
   input wire logic timer0_out,
   input wire logic timer1_out,
   input wire logic lcd_clk_src,
   input wire logic lcd_frame_src,
   input wire logic buzzer_src,
   input wire logic eighth_duty_opt,
   // pins
   output logic [7:0] port3_pins,
   output logic [1:0] port5_pins,
   output logic lcd_clk_pin,
   output logic lcd_frame_pin,
   output logic tone_out_pin,
   // control to neighbouring units
   output logic font_size_sel,
   output logic drive_duty_sel,
   output logic timer_width_sel,
   output logic prescaler1_src_sel,
   output logic prescaler0_src_sel,
   output logic decay_time_sel,
   output logic envelope_restart,
   output logic envelope_en,
   output logic oneshot_busy,
   output logic watchdog_rst,
   output logic clk_timer_rst,
   output logic clk_timer_run
);
   logic [7:0] port3_r;
   logic [7:0] port4_r;
   logic [1:0] port5_r;
   outport_pkg::lcd_ctl_t lcd_r;
   outport_pkg::tmr_mode_t tmr_r;
   outport_pkg::buzz_t buzz_r;
   logic [2:0] fsel_r;
   logic fout_en_r;
   logic tmrun_r;
   logic shot_r;
   logic [31:0] shot_cnt_r;
   logic [2:0] div_r;
   logic fout_r;
   outport_pkg::bus_state_t state_r;
   outport_pkg::av_req_t req;
   logic [23:0] idx;
   logic wr_en;
   logic [7:0] wd;
   logic shot_start;
   logic shot_stop;
   logic shot_done;
   logic osc_tick;
   logic [7:0] rd_nxt;

   // decode register index from the word address
   function automatic logic hit(input logic [23:0] i, input logic [23:0] r);
      hit = (i == r);
   endfunction : hit

   assign req = '{avs_read, avs_write, avs_address, avs_writedata};
   assign idx = req.addr[25:2];
   assign wd = req.wdata[7:0];
   assign wr_en = req.wr && state_r == outport_pkg::bus_ack
      && avs_byteenable[0];

   // request is held one cycle, then answered
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= outport_pkg::bus_idle;
         avs_waitrequest <= 1'b1;
      end else begin
         unique case (state_r)
            outport_pkg::bus_idle: begin
               if ((req.rd || req.wr) && avs_waitrequest) begin
                  state_r <= outport_pkg::bus_ack;
                  avs_waitrequest <= 1'b0;
               end else begin
                  avs_waitrequest <= 1'b1;
               end
            end
            outport_pkg::bus_ack: begin
               state_r <= outport_pkg::bus_idle;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // read mux; unused bits and trigger bits other than buzzer d5 read zero
   always_comb begin
      rd_nxt = 8'h00;
      if (hit(idx, outport_pkg::port3_idx)) begin
         rd_nxt = port3_r;
      end else if (hit(idx, outport_pkg::port4_idx)) begin
         rd_nxt = port4_r;
      end else if (hit(idx, outport_pkg::port5_idx)) begin
         rd_nxt = {6'h00, port5_r};
      end else if (hit(idx, outport_pkg::lcd_ctl_idx)) begin
         rd_nxt = {3'h0, lcd_r};
      end else if (hit(idx, outport_pkg::tmr_mode_idx)) begin
         rd_nxt = {3'h0, tmr_r};
      end else if (hit(idx, outport_pkg::ctimer_idx)) begin
         rd_nxt = {1'b0, fsel_r, fout_en_r, 2'h0, tmrun_r};
      end else if (hit(idx, outport_pkg::buzz_idx)) begin
         rd_nxt = {2'h0, shot_r, buzz_r.len, buzz_r.decay, 1'b0,
            buzz_r.env, buzz_r.bz};
      end else if (hit(idx, outport_pkg::build_opt_idx)) begin
         rd_nxt = {7'h00, eighth_duty_opt};
      end
   end

   // read data registered with the answer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= 32'h0;
      end else if (req.rd && state_r == outport_pkg::bus_idle) begin
         avs_readdata <= {24'h0, rd_nxt};
      end
   end

   // port data registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         port3_r <= outport_pkg::port3_rst;
         port4_r <= outport_pkg::port4_rst;
         port5_r <= outport_pkg::port5_rst;
      end else if (wr_en) begin
         if (hit(idx, outport_pkg::port3_idx)) begin
            port3_r <= wd;
         end
         if (hit(idx, outport_pkg::port4_idx)) begin
            port4_r <= wd;
         end
         if (hit(idx, outport_pkg::port5_idx)) begin
            port5_r <= wd[1:0];
         end
      end
   end

   // lcd and timer mode control
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lcd_r <= '0;
         tmr_r <= '0;
      end else if (wr_en) begin
         if (hit(idx, outport_pkg::lcd_ctl_idx)) begin
            lcd_r <= wd[4:0];
         end
         if (hit(idx, outport_pkg::tmr_mode_idx)) begin
            tmr_r <= wd[4:0];
         end
      end
   end

   // clock timer register; reset bits pulse for one cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fsel_r <= 3'h0;
         fout_en_r <= 1'b0;
         tmrun_r <= 1'b0;
         watchdog_rst <= 1'b0;
         clk_timer_rst <= 1'b0;
      end else begin
         watchdog_rst <= 1'b0;
         clk_timer_rst <= 1'b0;
         if (wr_en && hit(idx, outport_pkg::ctimer_idx)) begin
            fsel_r <= wd[6:4];
            fout_en_r <= wd[outport_pkg::fout_pos];
            tmrun_r <= wd[outport_pkg::tmrun_pos];
            watchdog_rst <= wd[2];
            clk_timer_rst <= wd[1];
         end
      end
   end

   assign shot_start = wr_en && hit(idx, outport_pkg::buzz_idx)
      && wd[outport_pkg::shot_pos];
   assign shot_stop = wr_en && hit(idx, outport_pkg::buzz_idx)
      && wd[outport_pkg::stop_pos];
   assign shot_done = shot_r && shot_cnt_r == 32'h1;

   // buzzer control; envelope enable forced low while a one-shot runs
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         buzz_r <= '0;
         envelope_restart <= 1'b0;
      end else begin
         envelope_restart <= 1'b0;
         if (wr_en && hit(idx, outport_pkg::buzz_idx)) begin
            buzz_r <= {wd[4], wd[3], wd[1], wd[0]};
            envelope_restart <= wd[outport_pkg::erst_pos];
         end
         if (shot_r || shot_start) begin
            buzz_r.env <= 1'b0;
         end
      end
   end

   // one-shot timer: stop wins over start, start wins over expiry
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         shot_r <= 1'b0;
         shot_cnt_r <= 32'h0;
      end else if (shot_stop) begin
         shot_r <= 1'b0;
         shot_cnt_r <= 32'h0;
      end else if (shot_done && !shot_start) begin
         shot_r <= 1'b0; // countdown expired, back to ready
         shot_cnt_r <= 32'h0;
      end else if (shot_start) begin
         shot_r <= 1'b1;
         shot_cnt_r <= wd[outport_pkg::len_pos]
            ? 32'(outport_pkg::shot_long_cyc)
            : 32'(outport_pkg::shot_short_cyc);
      end else if (shot_r) begin
         shot_cnt_r <= shot_cnt_r - 32'h1;
      end
   end

   assign osc_tick = fsel_r[2] ? high_speed_osc : low_speed_osc;

   // frequency divider toggles on oscillator ticks
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         div_r <= 3'h0;
         fout_r <= 1'b0;
      end else if (osc_tick) begin
         div_r <= div_r + 3'h1;
         unique case (fsel_r[1:0])
            2'h0: fout_r <= ~fout_r;
            2'h1: fout_r <= div_r[0] ? ~fout_r : fout_r;
            2'h2: fout_r <= (div_r[1:0] == 2'h3) ? ~fout_r : fout_r;
            2'h3: fout_r <= (div_r == 3'h7) ? ~fout_r : fout_r;
         endcase
      end
   end

   // pin muxing: special functions override port data
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         port3_pins <= outport_pkg::port3_rst;
         port5_pins <= outport_pkg::port5_rst;
         lcd_clk_pin <= 1'b0;
         lcd_frame_pin <= 1'b0;
         tone_out_pin <= 1'b0;
      end else begin
         port3_pins <= port3_r;
         port3_pins[4] <= fout_en_r ? fout_r : port3_r[4];
         port5_pins[1] <= port5_r[1];
         port5_pins[0] <= (buzz_r.bz || shot_r)
            ? buzzer_src : port5_r[0];
         lcd_clk_pin <= lcd_r.clk_en & lcd_clk_src;
         lcd_frame_pin <= lcd_r.frm_en & lcd_frame_src;
         tone_out_pin <= tmr_r.tone
            & (tmr_r.chan ? timer1_out : timer0_out);
      end
   end

   // control outputs to neighbouring units
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         font_size_sel <= 1'b0;
         drive_duty_sel <= 1'b0;
         timer_width_sel <= 1'b0;
         prescaler1_src_sel <= 1'b0;
         prescaler0_src_sel <= 1'b0;
         decay_time_sel <= 1'b0;
         envelope_en <= 1'b0;
         oneshot_busy <= 1'b0;
         clk_timer_run <= 1'b0;
      end else begin
         font_size_sel <= lcd_r.font;
         drive_duty_sel <= lcd_r.duty & ~eighth_duty_opt;
         timer_width_sel <= tmr_r.width;
         prescaler1_src_sel <= tmr_r.psc1;
         prescaler0_src_sel <= tmr_r.psc0;
         decay_time_sel <= buzz_r.decay;
         envelope_en <= buzz_r.env;
         oneshot_busy <= shot_r;
         clk_timer_run <= tmrun_r;
      end
   end

   // checks
   bus_answer_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (avs_read || avs_write) && avs_waitrequest
      && state_r == outport_pkg::bus_idle |=> !avs_waitrequest)
      else $error("bus answer late");
   port3_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_en && hit(idx, outport_pkg::port3_idx)
      |=> ##1 port3_pins == $past(wd, 2) || fout_en_r)
      else $error("port3 pins wrong");
   shot_busy_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      shot_start && !shot_stop |=> shot_r ##1 oneshot_busy)
      else $error("one-shot not busy");
   shot_stop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      shot_stop |=> !shot_r)
      else $error("one-shot not stopped");
   env_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      shot_r |=> !buzz_r.env)
      else $error("envelope not cleared");
   duty_mask_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      $past(eighth_duty_opt) |-> !drive_duty_sel)
      else $error("duty not masked");
   tone_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !$past(tmr_r.tone) |-> !tone_out_pin)
      else $error("tone pin active");
   trig_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      envelope_restart |=> !envelope_restart)
      else $error("trigger stuck");
   ctl_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      watchdog_rst || clk_timer_rst |=> !watchdog_rst && !clk_timer_rst)
      else $error("reset pulse stuck");
   tone_chan_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      tmr_r.tone && !tmr_r.chan |=> tone_out_pin == $past(timer0_out))
      else $error("tone channel wrong");
   lcd_clk_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !lcd_r.clk_en |=> !lcd_clk_pin)
      else $error("lcd clock not gated");
   lcd_frame_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !lcd_r.frm_en |=> !lcd_frame_pin)
      else $error("lcd frame not gated");
   port5_data_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !buzz_r.bz && !shot_r |=> port5_pins[0] == $past(port5_r[0]))
      else $error("port5 pin wrong");
   fout_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !fout_en_r |=> port3_pins[4] == $past(port3_r[4]))
      else $error("frequency pin wrong");
endmodule : outport_bank

// ### dv/pin_loads.sv
// Purpose: loads on the port pins, counting edges on the frequency pin
// Assumes: pins are registered outputs of the bank, sampled on sys_clk
// Notes: the loads only watch; no pin is driven back into the device
module pin_loads (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // pins seen by the loads
   input wire logic [7:0] port3_pins,
   input wire logic [1:0] port5_pins,
   input wire logic lcd_clk_pin,
   input wire logic lcd_frame_pin,
   input wire logic tone_out_pin,
   // edge counter control and result
   input wire logic clr,
   output logic [15:0] freq_edges
);
   timeunit 1ns;
   timeprecision 1ps;
   logic freq_last_r;
   // count level changes on the shared frequency pin
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         freq_last_r <= 1'b1;
         freq_edges <= 16'h0;
      end else begin
         freq_last_r <= port3_pins[4];
         if (clr) begin
            freq_edges <= 16'h0;
         end else if (port3_pins[4] != freq_last_r) begin
            freq_edges <= freq_edges + 16'h1;
         end
      end
   end
endmodule : pin_loads

// ### dv/tb_top.sv
// Purpose: self-checking bench for the output port register bank
// Assumes: one wait state per access, register index times four is address
// Notes: one-shot lengths are millions of cycles, so only start/stop checked
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [23:0] idx;
      logic [7:0] wd;
      logic [7:0] exp;
   } row_t;
   logic sys_clk = 1'b0, rstn = 1'b0;
   logic [25:0] avs_address = 26'h0;
   logic avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0] avs_byteenable = 4'h0;
   logic avs_waitrequest;
   logic low_speed_osc = 1'b0, high_speed_osc = 1'b0;
   logic timer0_out = 1'b1, timer1_out = 1'b0;
   logic lcd_clk_src = 1'b1, lcd_frame_src = 1'b1, buzzer_src = 1'b0;
   logic eighth_duty_opt = 1'b0, clr = 1'b0;
   logic [7:0] port3_pins;
   logic [1:0] port5_pins;
   logic lcd_clk_pin, lcd_frame_pin, tone_out_pin, font_size_sel;
   logic drive_duty_sel, timer_width_sel, prescaler1_src_sel;
   logic prescaler0_src_sel, decay_time_sel, envelope_restart, envelope_en;
   logic oneshot_busy, watchdog_rst, clk_timer_rst, clk_timer_run;
   logic [15:0] freq_edges;
   logic [1:0] tick_cnt = 2'h0;
   logic [7:0] d;
   int n_errors = 0, n_tests = 0, e, pulse;
   row_t rows [8] = '{
      '{24'h00ff76, 8'h5a, 8'h5a}, '{24'h00ff77, 8'h3c, 8'h3c},
      '{24'h00ff78, 8'hff, 8'h03}, '{24'h00ff10, 8'hff, 8'h1f},
      '{24'h00ff30, 8'hff, 8'h1f}, '{24'h00ff44, 8'h1b, 8'h1b},
      '{24'h00ff40, 8'h70, 8'h70}, '{24'h00ff7f, 8'hff, 8'h00}};
   row_t rst_rows [7] = '{
      '{24'h00ff76, 8'h0, 8'hff}, '{24'h00ff77, 8'h0, 8'hff},
      '{24'h00ff78, 8'h0, 8'h02}, '{24'h00ff10, 8'h0, 8'h00},
      '{24'h00ff30, 8'h0, 8'h00}, '{24'h00ff44, 8'h0, 8'h00},
      '{24'h00ff40, 8'h0, 8'h00}};
   // clock and oscillator ticks: low every 4 cycles, high every 2
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      tick_cnt <= tick_cnt + 2'h1;
      low_speed_osc <= (tick_cnt == 2'h3);
      high_speed_osc <= tick_cnt[0];
   end
   outport_bank u_outport_bank (.sys_clk(sys_clk), .rstn(rstn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .low_speed_osc(low_speed_osc),
      .high_speed_osc(high_speed_osc), .timer0_out(timer0_out),
      .timer1_out(timer1_out), .lcd_clk_src(lcd_clk_src),
      .lcd_frame_src(lcd_frame_src), .buzzer_src(buzzer_src),
      .eighth_duty_opt(eighth_duty_opt), .port3_pins(port3_pins),
      .port5_pins(port5_pins), .lcd_clk_pin(lcd_clk_pin),
      .lcd_frame_pin(lcd_frame_pin), .tone_out_pin(tone_out_pin),
      .font_size_sel(font_size_sel), .drive_duty_sel(drive_duty_sel),
      .timer_width_sel(timer_width_sel),
      .prescaler1_src_sel(prescaler1_src_sel),
      .prescaler0_src_sel(prescaler0_src_sel),
      .decay_time_sel(decay_time_sel), .envelope_restart(envelope_restart),
      .envelope_en(envelope_en), .oneshot_busy(oneshot_busy),
      .watchdog_rst(watchdog_rst), .clk_timer_rst(clk_timer_rst),
      .clk_timer_run(clk_timer_run));
   pin_loads u_pin_loads (.sys_clk(sys_clk), .rstn(rstn),
      .port3_pins(port3_pins), .port5_pins(port5_pins),
      .lcd_clk_pin(lcd_clk_pin), .lcd_frame_pin(lcd_frame_pin),
      .tone_out_pin(tone_out_pin), .clr(clr), .freq_edges(freq_edges));
   // verdict and end of run
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize
   // compare seen against expected
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one avalon transfer, held until waitrequest is sampled low
   task automatic av(input logic wr, input logic [23:0] idx,
         input logic [7:0] wd, input logic [3:0] be, output logic [7:0] rd);
      int n;
      @(posedge sys_clk);
      avs_address <= {idx, 2'b00};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, wd};
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         summarize();
      end
   endtask : av
   // read what two edges after a write launched, before the third updates
   task automatic settle();
      repeat (3) @(posedge sys_clk);
   endtask : settle
   // main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         av(1'b1, rows[i].idx, rows[i].wd, 4'h1, d);
         av(1'b0, rows[i].idx, 8'h0, 4'h1, d);
         chk(d, rows[i].exp);
      end
      settle();
      chk({font_size_sel, timer_width_sel, prescaler1_src_sel,
         prescaler0_src_sel, decay_time_sel, envelope_en},
         6'h3f);
      chk(drive_duty_sel, 1'b1);
      chk(port3_pins, 8'h5a);
      chk(port5_pins, 2'h2);
      $display("table rows done");
      eighth_duty_opt <= 1'b1;
      settle();
      chk(drive_duty_sel, 1'b0);
      av(1'b1, 24'h00ff76, 8'h00, 4'h0, d);
      av(1'b0, 24'h00ff76, 8'h00, 4'h1, d);
      chk(d, 8'h5a);
      // tone channel and lcd outputs
      av(1'b1, 24'h00ff30, 8'h04, 4'h1, d);
      settle();
      chk(tone_out_pin, 1'b1);
      av(1'b1, 24'h00ff30, 8'h0c, 4'h1, d);
      settle();
      chk(tone_out_pin, 1'b0);
      av(1'b1, 24'h00ff10, 8'h10, 4'h1, d);
      settle();
      chk({lcd_clk_pin, lcd_frame_pin}, 2'h2);
      av(1'b1, 24'h00ff10, 8'h08, 4'h1, d);
      settle();
      chk({lcd_clk_pin, lcd_frame_pin}, 2'h1);
      $display("special outputs done");
      // one-shot start, hardware envelope clear, forced stop
      av(1'b1, 24'h00ff44, 8'h22, 4'h1, d);
      av(1'b0, 24'h00ff44, 8'h00, 4'h1, d);
      chk(d, 8'h20);
      chk(oneshot_busy, 1'b1);
      av(1'b1, 24'h00ff44, 8'h40, 4'h1, d);
      av(1'b0, 24'h00ff44, 8'h00, 4'h1, d);
      chk(d, 8'h00);
      pulse = 0;
      av(1'b1, 24'h00ff44, 8'h04, 4'h1, d);
      repeat (4) begin
         @(posedge sys_clk);
         if (envelope_restart === 1'b1) pulse++;
      end
      chk(pulse, 1);
      av(1'b0, 24'h00ff44, 8'h00, 4'h1, d);
      chk(d, 8'h00);
      $display("one-shot done");
      // every frequency code, counted at the pin
      for (int c = 0; c < 8; c++) begin
         av(1'b1, 24'h00ff40, {1'b0, c[2:0], 4'h8}, 4'h1, d);
         settle();
         clr <= 1'b1;
         @(posedge sys_clk);
         clr <= 1'b0;
         repeat (160) @(posedge sys_clk);
         e = (c < 4 ? 40 : 80) >> c[1:0];
         chk(freq_edges >= e - 2 && freq_edges <= e + 2, 1);
      end
      av(1'b1, 24'h00ff40, 8'h07, 4'h1, d);
      @(posedge sys_clk);
      chk({watchdog_rst, clk_timer_rst}, 2'h3);
      av(1'b0, 24'h00ff40, 8'h00, 4'h1, d);
      chk(d, 8'h01);
      chk({watchdog_rst, clk_timer_rst, clk_timer_run}, 3'h1);
      av(1'b1, 24'h00ff40, 8'h00, 4'h1, d);
      settle();
      chk(port3_pins[4], 1'b1);
      $display("frequency codes done");
      // reset in mid-run, then every reset value
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({port3_pins, port5_pins}, 10'h3fe);
      rstn <= 1'b1;
      foreach (rst_rows[i]) begin
         av(1'b0, rst_rows[i].idx, 8'h0, 4'h1, d);
         chk(d, rst_rows[i].exp);
      end
      $display("reset values done");
      summarize();
   end
endmodule : tb_top
